// *** hbc_pkg.sv ***
// Constants shared by the H-bridge host controller.
// Assumes a 125 MHz system clock; all times are rounded to cycles here.
package hbc_pkg;
    localparam int CLK_MHZ = 125;
    // Times in nanoseconds
    localparam int CLR_MIN_NS = 3100;
    localparam int CLR_MAX_NS = 3600;
    localparam int OFF_MIN_NS = 7000;
    localparam int REFRESH_NS = 1000;
    localparam int MAX_ON_NS = 1000000;
    localparam int CHARGE_NS = 1000;
    // Least times round up, longest times round down
    localparam int CLR_MIN_CYC = (CLR_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CLR_MAX_CYC = (CLR_MAX_NS * CLK_MHZ) / 1000;
    localparam int OFF_MIN_CYC = (OFF_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / 1000;
    localparam int CHARGE_CYC = (CHARGE_NS * CLK_MHZ + 999) / 1000;
    // Midpoint of the diagnosis clear window
    localparam int CLR_CYC = (CLR_MIN_CYC + CLR_MAX_CYC) / 2;
    // Extra margin above the shutdown time
    localparam int OFF_CYC = OFF_MIN_CYC + 16;

    // Host register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DUTY = 4'h1;
    localparam logic [3:0] REG_PERIOD = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CHARGE = 4'h5;
    // CTRL fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_FAST = 2;
    localparam int CTRL_AWAKE = 3;
    // CMD fields
    localparam int CMD_CLEAR = 0;
    localparam int CMD_START = 1;
    localparam logic [15:0] PERIOD_RST = 16'h1869;
    localparam logic [15:0] CHARGE_RST = 16'hFFFF;

    typedef enum logic [1:0] {
        HBC_ST_OK, HBC_ST_WARN, HBC_ST_SHORT, HBC_ST_UV
    } hbc_stat_t;

    typedef enum {
        HBC_OFF, HBC_CHARGE, HBC_RUN, HBC_CLEAR
    } hbc_state_t;
endpackage

// *** hbc_pulse.sv ***
// Pulse-width generator with bootstrap duty limit and refresh insertion.
// Assumes duty and period registers are stable across a period.
`timescale 1ns/1ps
module hbc_pulse
    import hbc_pkg::*;
#(
    parameter int W = 16,
    parameter int MAX_ON = MAX_ON_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [W-1:0] period,
    input wire logic [W-1:0] duty,
    input wire logic high_drain,
    output logic pulse
);
    logic [W-1:0] count;
    logic [W-1:0] on_lim;
    logic [W-1:0] on_end;
    logic [31:0] hi_run;
    logic [7:0] refresh;

    // Keep a charging gap each period
    always_comb begin
        on_lim = (period > W'(CHARGE_CYC)) ? period - W'(CHARGE_CYC) : '0;
        on_end = (duty > on_lim) ? on_lim : duty;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!run || count >= period) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    // Long high-side stretches above supply need a refresh
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_run <= '0;
            refresh <= '0;
        end else if (refresh != 8'h00) begin
            refresh <= refresh - 8'h01;
            hi_run <= '0;
        end else if (run && high_drain && !pulse) begin
            if (hi_run >= 32'(MAX_ON)) begin
                refresh <= 8'(REFRESH_CYC);
            end
            hi_run <= hi_run + 32'h1;
        end else begin
            hi_run <= '0;
        end
    end

    // Pulse 1 lights the low side for the non-duty part
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse <= 1'b0;
        end else begin
            pulse <= run &&
                ((refresh != 8'h00) || count >= on_end);
        end
    end
endmodule // hbc_pulse

// *** hbc_host.sv ***
// Host controller for a clockless H-bridge gate driver.
// Assumes the driver's flags and pins are asynchronous to clock.
// How it works
// - Host clears diagnosis with a high pulse inside the reset window.
// - Host starts disabled, waits charge time, enables, then switches.
// - Duty value sets high-side share; low gate holds the rest.
// - Host inserts refresh pulse after long high-side on-time.
// - Host limits duty to leave bootstrap charging time.
// - Fast decay holds pulse at 1 and switches direction.
`timescale 1ns/1ps
module hbc_host
    import hbc_pkg::*;
#(
    parameter int W = 16,
    parameter int MAX_ON = MAX_ON_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [W-1:0] rdata,
    input wire logic shutdown_error_flag,
    input wire logic cause_warning_flag,
    output logic direction_out,
    output logic pwm_out,
    output logic deadtime_disable_pin,
    output logic inhibit_n
);
    logic rst_m;
    logic rst_n;
    logic [1:0] flag_a;
    logic [1:0] flag_b;
    logic [W-1:0] ctrl;
    logic [W-1:0] duty;
    logic [W-1:0] period;
    logic [W-1:0] charge;
    logic [15:0] timer;
    logic clear_req;
    logic start_req;
    logic short_seen;
    hbc_stat_t stat;
    hbc_stat_t stat_prev;
    logic [15:0] clr_len;
    hbc_state_t state;
    logic pulse;
    logic run;

    function automatic hbc_stat_t decode(input logic sd, input logic cw);
        case ({sd, cw})
            2'b11: decode = HBC_ST_OK;
            2'b10: decode = HBC_ST_WARN;
            2'b01: decode = HBC_ST_SHORT;
            default: decode = HBC_ST_UV;
        endcase
    endfunction

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Two-stage sync of the open-drain flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_a <= 2'b11;
            flag_b <= 2'b11;
        end else begin
            flag_a <= {shutdown_error_flag, cause_warning_flag};
            flag_b <= flag_a;
        end
    end

    // Status decode; short, undervoltage and warning all via flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat <= HBC_ST_OK;
            stat_prev <= HBC_ST_OK;
        end else begin
            stat <= decode(flag_b[1], flag_b[0]);
            stat_prev <= stat;
        end
    end

    // Sticky short flag; a new short wins over the clear.
    // Set on entry only: the flags lag the clear pulse by a few cycles,
    // so a level set would latch the old short again.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            short_seen <= 1'b0;
        end else if (stat == HBC_ST_SHORT && stat_prev != HBC_ST_SHORT) begin
            short_seen <= 1'b1;
        end else if (state == HBC_CLEAR && timer == 16'h0000) begin
            short_seen <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
            duty <= '0;
            period <= W'(PERIOD_RST);
            charge <= W'(CHARGE_RST);
        end else if (wr) begin
            case (addr)
                REG_CTRL: ctrl <= wdata;
                REG_DUTY: duty <= wdata;
                REG_PERIOD: period <= wdata;
                REG_CHARGE: charge <= wdata;
                default: ;
            endcase
        end
    end

    // Command strobes, held until the state machine takes them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clear_req <= 1'b0;
            start_req <= 1'b0;
        end else begin
            if (wr && addr == REG_CMD && wdata[CMD_CLEAR]) begin
                clear_req <= 1'b1;
            end else if (state != HBC_RUN) begin
                // Dropped outside running, so a stale clear never fires
                clear_req <= 1'b0;
            end
            if (wr && addr == REG_CMD && wdata[CMD_START]) begin
                start_req <= 1'b1;
            end else if (state != HBC_OFF || !ctrl[CTRL_ENABLE] ||
                !ctrl[CTRL_AWAKE]) begin
                start_req <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                REG_CTRL: rdata <= ctrl;
                REG_DUTY: rdata <= duty;
                REG_PERIOD: rdata <= period;
                REG_CHARGE: rdata <= charge;
                REG_STATUS: rdata <= W'({short_seen, state == HBC_RUN,
                    stat});
                default: rdata <= '0;
            endcase
        end
    end

    // Sequencer: disabled, charging, running, clear pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= HBC_OFF;
            timer <= '0;
        end else begin
            case (state)
                HBC_OFF: begin
                    if (start_req && ctrl[CTRL_ENABLE] &&
                        ctrl[CTRL_AWAKE]) begin
                        state <= HBC_CHARGE;
                        timer <= 16'(charge);
                    end
                end
                HBC_CHARGE: begin
                    if (!ctrl[CTRL_ENABLE]) begin
                        state <= HBC_OFF;
                    end else if (timer == 16'h0000) begin
                        state <= HBC_RUN;
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                HBC_RUN: begin
                    if (!ctrl[CTRL_ENABLE] || !ctrl[CTRL_AWAKE]) begin
                        state <= HBC_OFF;
                    end else if (clear_req) begin
                        state <= HBC_CLEAR;
                        timer <= 16'(CLR_CYC - 1);
                    end
                end
                HBC_CLEAR: begin
                    if (timer == 16'h0000) begin
                        state <= HBC_RUN;
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
                default: state <= HBC_OFF;
            endcase
        end
    end

    // Disable pin high outside running; clear pulse is short
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            deadtime_disable_pin <= 1'b1;
        end else begin
            deadtime_disable_pin <= (state != HBC_RUN);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_n <= 1'b0;
        end else begin
            inhibit_n <= ctrl[CTRL_AWAKE];
        end
    end

    assign run = (state == HBC_RUN) && !ctrl[CTRL_FAST];

    hbc_pulse #(.W(W), .MAX_ON(MAX_ON)) hbc_pulse_i (
        .clock(clock),
        .rst_n(rst_n),
        .run(state == HBC_RUN),
        .period(period),
        .duty(duty),
        .high_drain(1'b1),
        .pulse(pulse)
    );

    // Fast decay drives the pattern on direction; no switching pre-charge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
            direction_out <= 1'b0;
        end else if (state != HBC_RUN) begin
            pwm_out <= 1'b0;
            direction_out <= 1'b0;
        end else if (run) begin
            pwm_out <= pulse;
            direction_out <= ctrl[CTRL_DIR];
        end else begin
            pwm_out <= 1'b1;
            direction_out <= pulse ^ ctrl[CTRL_DIR];
        end
    end

    // Length of each clear pulse, for the window check
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clr_len <= '0;
        end else if (state == HBC_CLEAR) begin
            clr_len <= clr_len + 16'h0001;
        end else begin
            clr_len <= '0;
        end
    end

    clear_width_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(deadtime_disable_pin) && $past(state) == HBC_CLEAR |->
        deadtime_disable_pin [*8])
        else $error("clear pulse too short");
    clear_end_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(state == HBC_CLEAR) |-> ##[1:450] state == HBC_RUN)
        else $error("clear pulse too long");
    clear_len_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        $fell(state == HBC_CLEAR) |-> clr_len >= 16'(CLR_MIN_CYC) &&
        clr_len <= 16'(CLR_MAX_CYC))
        else $error("clear pulse outside window");
    run_pin_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == HBC_RUN |=> !deadtime_disable_pin)
        else $error("pin high while running");
    off_pin_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == HBC_OFF |=> deadtime_disable_pin)
        else $error("pin low while off");
    idle_pwm_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        state != HBC_RUN |=> !pwm_out)
        else $error("pulses before running");
    stat_dec_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        flag_b == 2'b01 |=> stat == HBC_ST_SHORT)
        else $error("short decode wrong");
    short_stk_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        stat == HBC_ST_SHORT && stat_prev != HBC_ST_SHORT |=> short_seen)
        else $error("short not latched");
    wake_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ctrl[CTRL_AWAKE] |=> !inhibit_n)
        else $error("awake while asleep");
    fast_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == HBC_RUN && ctrl[CTRL_FAST] |=> pwm_out)
        else $error("fast decay pulse low");

    run_c: cover property (@(posedge clock) disable iff (!rst_n)
        state == HBC_RUN);
    clear_c: cover property (@(posedge clock) disable iff (!rst_n)
        state == HBC_CLEAR);
    short_c: cover property (@(posedge clock) disable iff (!rst_n)
        short_seen);
    fast_c: cover property (@(posedge clock) disable iff (!rst_n)
        state == HBC_RUN && ctrl[CTRL_FAST]);
endmodule // hbc_host

// *** hbc_drv_model.sv ***
// Behavioural H-bridge gate driver seen from its logic pins and flags.
// Assumes a host drives the pins; faults come from the bench as levels.
`timescale 1ns/1ps
module hbc_drv_model (
    input wire logic direction_out,
    input wire logic pwm_out,
    input wire logic deadtime_disable_pin,
    input wire logic inhibit_n,
    input wire logic [7:0] temp,
    input wire logic short_vds_criterion,
    input wire logic uv,
    output logic shutdown_error_flag,
    output logic cause_warning_flag,
    output logic [3:0] gates,
    output logic off
);
    logic ot = 1'b0;
    logic sc_lat = 1'b0;
    realtime t_dis = 0;
    realtime t_sc = 0;
    // Floating pins fall to their weak defaults
    wire d = direction_out === 1'b1;
    wire p = pwm_out === 1'b1;
    wire dis = deadtime_disable_pin !== 1'b0;
    initial off = 1'b0;
    always @(temp) begin
        if (temp > 8'hAA)
            ot = 1'b1;
        else if (temp < 8'h96)
            ot = 1'b0;
    end
    always @(posedge short_vds_criterion) t_sc = $realtime;
    // Restart on every rise, so brief shorts never add up
    always @(posedge short_vds_criterion) begin
        #9000;
        if (short_vds_criterion && $realtime - t_sc >= 9000)
            sc_lat = 1'b1;
    end
    always @(posedge dis) t_dis = $realtime;
    // Timed from the latest rise, so a stale rise never stops outputs
    always @(posedge dis) begin
        #7001;
        if (dis && $realtime - t_dis >= 7001)
            off = 1'b1;
    end
    always @(negedge dis) begin
        off = 1'b0;
        if ($realtime - t_dis >= 3100)
            sc_lat = 1'b0;
    end
    always @(negedge inhibit_n) sc_lat = 1'b0;
    // Gate order: high 1, low 1, high 2, low 2
    always_comb begin
        if (off || inhibit_n !== 1'b1)
            gates = 4'h0;
        else if (!p)
            gates = 4'hA;
        else if (!d)
            gates = 4'h9;
        else
            gates = 4'h6;
    end
    // Open drain: a released flag shows the pull-up level
    always_comb begin
        shutdown_error_flag = !(inhibit_n && (uv || sc_lat));
        cause_warning_flag = !(inhibit_n && (uv || (ot && !sc_lat)));
    end
endmodule // hbc_drv_model

// *** hbc_host_tb.sv ***
// Self-checking bench for the H-bridge host controller.
// Assumes the driver model is compiled before this file.
`timescale 1ns/1ps
module hbc_host_tb;
    import hbc_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata, rv;
    logic shutdown_error_flag, cause_warning_flag, off;
    logic direction_out, pwm_out, deadtime_disable_pin, inhibit_n;
    logic [7:0] temp = 8'h19;
    logic sc = 1'b0;
    logic uv = 1'b0;
    logic [3:0] gates;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;

    always #4 clock = ~clock;

    hbc_host hbc_host_i (.clock, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
        .shutdown_error_flag, .cause_warning_flag, .direction_out,
        .pwm_out, .deadtime_disable_pin, .inhibit_n);
    hbc_drv_model hbc_drv_model_i (.direction_out, .pwm_out,
        .deadtime_disable_pin, .inhibit_n, .temp, .short_vds_criterion(sc),
        .uv, .shutdown_error_flag, .cause_warning_flag, .gates, .off);

    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Each access starts on an edge, so strobes never double up
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic st(input logic [1:0] code);
        repeat (4) @(posedge clock);
        rreg(REG_STATUS);
        chk({14'h0, rv[1:0]}, {14'h0, code});
    endtask

    task automatic wait_pin(input logic v);
        int n = 0;
        while (deadtime_disable_pin !== v && n < 100) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic t_reset;
        @(negedge clock);
        chk({deadtime_disable_pin, pwm_out, direction_out, inhibit_n},
            16'h8);
        rreg(REG_PERIOD);
        chk(rv, PERIOD_RST);
        rreg(REG_CHARGE);
        chk(rv, CHARGE_RST);
        rreg(4'h6);
        chk(rv, 16'h0000);
        st(2'h0);
    endtask

    task automatic t_start;
        int n = 0;
        wreg(REG_CHARGE, 16'h0028);
        wreg(REG_PERIOD, 16'h0190);
        wreg(REG_DUTY, 16'h0064);
        wreg(REG_CTRL, 16'h0009);
        repeat (2) @(negedge clock);
        chk({15'h0, inhibit_n}, 16'h0001);
        wreg(REG_CMD, 16'h0002);
        repeat (30) begin
            @(negedge clock);
            n += (pwm_out !== 1'b0 || deadtime_disable_pin !== 1'b1);
        end
        chk(n[15:0], 16'h0000);
        wait_pin(1'b0);
        chk({15'h0, deadtime_disable_pin}, 16'h0000);
    endtask

    task automatic t_duty(input logic [15:0] duty, input logic [15:0] lows);
        int n = 0;
        int m = 0;
        wreg(REG_DUTY, duty);
        repeat (1200) @(negedge clock);
        // Period register holds the length minus one
        repeat (401) begin
            @(negedge clock);
            n += (pwm_out === 1'b0);
            m += (gates[0] === 1'b1);
        end
        chk(n[15:0], lows);
        chk(m[15:0], 16'h0191 - lows);
    endtask

    task automatic t_diag;
        temp <= 8'hB4;
        st(2'h1);
        temp <= 8'hA0;
        st(2'h1);
        temp <= 8'h8C;
        st(2'h0);
        repeat (2) begin
            sc <= 1'b1;
            repeat (600) @(posedge clock);
            sc <= 1'b0;
            @(posedge clock);
        end
        st(2'h0);
        sc <= 1'b1;
        repeat (1200) @(posedge clock);
        sc <= 1'b0;
        st(2'h2);
        chk({15'h0, rv[3]}, 16'h0001);
        uv <= 1'b1;
        st(2'h3);
        uv <= 1'b0;
        st(2'h2);
    endtask

    task automatic t_clear;
        int n = 0;
        wreg(REG_CMD, 16'h0001);
        wait_pin(1'b1);
        while (deadtime_disable_pin === 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        chk(16'(n >= CLR_MIN_CYC && n <= CLR_MAX_CYC),
            16'h1);
        chk({15'h0, off}, 16'h0000);
        st(2'h0);
        chk({15'h0, rv[3]}, 16'h0000);
    endtask

    task automatic t_mode;
        int n = 0;
        int m = 0;
        wreg(REG_CTRL, 16'h000B);
        // Direction follows the write one cycle late
        repeat (2) @(negedge clock);
        repeat (403) begin
            @(negedge clock);
            n += (pwm_out === 1'b1 ? gates !== 4'h6 : gates !== 4'hA);
        end
        chk(n[15:0], 16'h0000);
        wreg(REG_CTRL, 16'h000D);
        repeat (3) @(negedge clock);
        n = 0;
        repeat (802) begin
            @(negedge clock);
            m += (pwm_out !== 1'b1);
            n += (direction_out === 1'b0);
        end
        chk(m[15:0], 16'h0000);
        chk(n[15:0], 16'h0226);
    endtask

    task automatic t_stop;
        wreg(REG_CTRL, 16'h0008);
        repeat (1000) @(negedge clock);
        chk({deadtime_disable_pin, off, gates}, 16'h0030);
        wreg(REG_CTRL, 16'h0000);
        repeat (2) @(negedge clock);
        chk({15'h0, inhibit_n}, 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset();
        t_start();
        t_duty(16'h0064, 16'h0064);
        t_duty(16'h0186, 16'h0113);
        t_diag();
        t_clear();
        t_mode();
        t_stop();
        results();
    end
endmodule // hbc_host_tb
